// File: frl_defs.svh
`ifndef FRL_DEFS_SVH
`define FRL_DEFS_SVH

// ********************************************************************
// register offsets
// ********************************************************************
`define FRL_OFS_PWM1_CONFIG 8'h5C
`define FRL_OFS_PWM2_CONFIG 8'h5D
`define FRL_OFS_PWM3_CONFIG 8'h5E
`define FRL_OFS_RAMP_CTRL_A 8'h62
`define FRL_OFS_RAMP_CTRL_B 8'h63

// ********************************************************************
// field positions and reset values
// ********************************************************************
`define FRL_SLOW_BIT 3
`define FRL_A_STEP1_LSB 0
`define FRL_A_EN1_BIT 3
`define FRL_B_STEP3_LSB 0
`define FRL_B_EN3_BIT 3
`define FRL_B_STEP2_LSB 4
`define FRL_B_EN2_BIT 7
`define FRL_REG_RESET 8'h00
`define FRL_DUTY_RESET 8'h00
`define FRL_UNMAPPED_READ 8'h00

// ********************************************************************
// timing: full 0 to 255 ramp at one slot per update
// ********************************************************************
`define FRL_RAMP_FULL_MS 35000
`define FRL_CLK_KHZ 200000
`define FRL_SLOTS 255
`define FRL_SLOW_FACTOR_M1 2'h3

`endif

// File: frl_pkg.sv
package frl_pkg;

    typedef logic [7:0] frl_byte_t;
    typedef logic [2:0] frl_code_t;

    // register file state
    typedef struct packed {
        frl_byte_t [2:0] pwm_config;
        frl_byte_t ramp_ctrl_a;
        frl_byte_t ramp_ctrl_b;
        frl_byte_t rdata;
    } frl_regs_t;

    // ramp limiter state
    typedef struct packed {
        logic [31:0] tick_cnt;
        logic tick;
        logic [2:0][1:0] slow_cnt;
        frl_byte_t [2:0] duty;
    } frl_ramp_t;

endpackage : frl_pkg

// File: frl_reg_file.sv
`timescale 1ns/1ps
`default_nettype none
`include "frl_defs.svh"

module frl_reg_file
    import frl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic [7:0] o_pwm1_config,
    output logic [7:0] o_pwm2_config,
    output logic [7:0] o_pwm3_config,
    output logic [7:0] o_ramp_ctrl_a,
    output logic [7:0] o_ramp_ctrl_b
);

    frl_regs_t r_q;
    frl_regs_t r_d;

    // ****************************************************************
    // write decode and registered read data
    // ****************************************************************
    always_comb begin
        r_d = r_q;
        if (i_reg_wr) begin
            if (i_reg_addr == `FRL_OFS_PWM1_CONFIG) begin
                r_d.pwm_config[0] = i_reg_wdata;
            end else if (i_reg_addr == `FRL_OFS_PWM2_CONFIG) begin
                r_d.pwm_config[1] = i_reg_wdata;
            end else if (i_reg_addr == `FRL_OFS_PWM3_CONFIG) begin
                r_d.pwm_config[2] = i_reg_wdata;
            end else if (i_reg_addr == `FRL_OFS_RAMP_CTRL_A) begin
                r_d.ramp_ctrl_a = i_reg_wdata;
            end else if (i_reg_addr == `FRL_OFS_RAMP_CTRL_B) begin
                r_d.ramp_ctrl_b = i_reg_wdata;
            end
        end
        // read data holds until the next read strobe
        if (i_reg_rd) begin
            if (i_reg_addr == `FRL_OFS_PWM1_CONFIG) begin
                r_d.rdata = r_q.pwm_config[0];
            end else if (i_reg_addr == `FRL_OFS_PWM2_CONFIG) begin
                r_d.rdata = r_q.pwm_config[1];
            end else if (i_reg_addr == `FRL_OFS_PWM3_CONFIG) begin
                r_d.rdata = r_q.pwm_config[2];
            end else if (i_reg_addr == `FRL_OFS_RAMP_CTRL_A) begin
                r_d.rdata = r_q.ramp_ctrl_a;
            end else if (i_reg_addr == `FRL_OFS_RAMP_CTRL_B) begin
                r_d.rdata = r_q.ramp_ctrl_b;
            end else begin
                r_d.rdata = `FRL_UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            r_q.pwm_config <= {3{`FRL_REG_RESET}};
            r_q.ramp_ctrl_a <= `FRL_REG_RESET;
            r_q.ramp_ctrl_b <= `FRL_REG_RESET;
            r_q.rdata <= `FRL_UNMAPPED_READ;
        end else begin
            r_q <= r_d;
        end
    end

    assign o_reg_rdata = r_q.rdata;
    assign o_pwm1_config = r_q.pwm_config[0];
    assign o_pwm2_config = r_q.pwm_config[1];
    assign o_pwm3_config = r_q.pwm_config[2];
    assign o_ramp_ctrl_a = r_q.ramp_ctrl_a;
    assign o_ramp_ctrl_b = r_q.ramp_ctrl_b;

endmodule : frl_reg_file

`default_nettype wire

// File: frl_ramp_limiter.sv
`timescale 1ns/1ps
`default_nettype none
`include "frl_defs.svh"

module frl_ramp_limiter
    import frl_pkg::*;
#(
    // cycles between duty updates; one slot per update gives the full ramp
    parameter int unsigned UPDATE_CYC = int'(64'(`FRL_RAMP_FULL_MS)
        * 64'(`FRL_CLK_KHZ) / 64'(`FRL_SLOTS))
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_target_duty1,
    input wire logic [7:0] i_target_duty2,
    input wire logic [7:0] i_target_duty3,
    output logic [7:0] o_reg_rdata,
    output logic [7:0] o_duty1,
    output logic [7:0] o_duty2,
    output logic [7:0] o_duty3,
    output logic o_update
);

    // ****************************************************************
    // derived constants
    // ****************************************************************
    // last count of the update timer; sized once so the compare is clean
    localparam logic [31:0] TICK_LAST = 32'(UPDATE_CYC - 1);
    // last phase of the slow-mode counter, the one that lets a step through
    localparam logic [1:0] SLOW_LAST = `FRL_SLOW_FACTOR_M1;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // step size in slots for a 3-bit code
    function automatic frl_byte_t step_slots(input frl_code_t code);
        frl_byte_t s;
        s = 8'h01;
        case (code)
            3'h0: s = 8'h01;
            3'h1: s = 8'h02;
            3'h2: s = 8'h03;
            3'h3: s = 8'h05;
            3'h4: s = 8'h08;
            3'h5: s = 8'h0C;
            3'h6: s = 8'h18;
            3'h7: s = 8'h30;
            default: s = 8'h01;
        endcase
        return s;
    endfunction : step_slots

    // one step from prev toward tgt, never passing it
    function automatic frl_byte_t ramp_next(input frl_byte_t prev,
                                           input frl_byte_t tgt,
                                           input frl_byte_t step);
        frl_byte_t n;
        n = prev;
        if (tgt > prev) begin
            if (8'(tgt - prev) <= step) begin
                n = tgt;
            end else begin
                n = 8'(prev + step);
            end
        end else if (tgt < prev) begin
            if (8'(prev - tgt) <= step) begin
                n = tgt;
            end else begin
                n = 8'(prev - step);
            end
        end
        return n;
    endfunction : ramp_next

    // slow mode lets only every fourth update through; the counter keeps
    // running meanwhile, so toggling the slow bit does not reset the phase
    function automatic logic step_due(input logic slow,
                                      input logic [1:0] cnt);
        logic due;
        due = !slow || cnt == SLOW_LAST;
        return due;
    endfunction : step_due

    // ****************************************************************
    // register file
    // ****************************************************************
    logic [7:0] pwm_config [3];
    logic [7:0] ramp_ctrl_a;
    logic [7:0] ramp_ctrl_b;
    logic [7:0] reg_rdata;

    frl_reg_file u_regs (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd),
        .o_reg_rdata(reg_rdata),
        .o_pwm1_config(pwm_config[0]),
        .o_pwm2_config(pwm_config[1]),
        .o_pwm3_config(pwm_config[2]),
        .o_ramp_ctrl_a(ramp_ctrl_a),
        .o_ramp_ctrl_b(ramp_ctrl_b)
    );

    // ****************************************************************
    // per-output field decode
    // ****************************************************************
    frl_code_t ramp_step_sel_out1;
    frl_code_t ramp_step_sel_out2;
    frl_code_t ramp_step_sel_out3;
    frl_code_t step_code [3];
    logic ramp_en [3];
    logic slow_sel [3];
    frl_byte_t step_amt [3];
    frl_byte_t target [3];

    // field extraction from the two control registers
    assign ramp_step_sel_out1 = ramp_ctrl_a[`FRL_A_STEP1_LSB +: 3];
    assign ramp_step_sel_out3 = ramp_ctrl_b[`FRL_B_STEP3_LSB +: 3];
    assign ramp_step_sel_out2 = ramp_ctrl_b[`FRL_B_STEP2_LSB +: 3];

    // one code per output, in output order
    assign step_code[0] = ramp_step_sel_out1;
    assign step_code[1] = ramp_step_sel_out2;
    assign step_code[2] = ramp_step_sel_out3;

    // step size in slots, looked up once per output
    assign step_amt[0] = step_slots(step_code[0]);
    assign step_amt[1] = step_slots(step_code[1]);
    assign step_amt[2] = step_slots(step_code[2]);

    // per-output limiter enables
    assign ramp_en[0] = ramp_ctrl_a[`FRL_A_EN1_BIT];
    assign ramp_en[1] = ramp_ctrl_b[`FRL_B_EN2_BIT];
    assign ramp_en[2] = ramp_ctrl_b[`FRL_B_EN3_BIT];

    // slow bits live in the per-output config registers
    assign slow_sel[0] = pwm_config[0][`FRL_SLOW_BIT];
    assign slow_sel[1] = pwm_config[1][`FRL_SLOW_BIT];
    assign slow_sel[2] = pwm_config[2][`FRL_SLOW_BIT];

    // targets arrive on this clock from the duty calculation
    assign target[0] = i_target_duty1;
    assign target[1] = i_target_duty2;
    assign target[2] = i_target_duty3;

    // ****************************************************************
    // update timer and duty stepping
    // ****************************************************************
    frl_ramp_t s_q;
    frl_ramp_t s_d;

    // the update interval is one slot's share of the 35 s full ramp, so
    // larger steps shorten the full ramp in proportion
    always_comb begin
        s_d = s_q;
        // timer: count to the interval, then pulse for one cycle
        s_d.tick = 1'b0;
        if (s_q.tick_cnt >= TICK_LAST) begin
            s_d.tick_cnt = 32'h0000_0000;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = 32'(s_q.tick_cnt + 32'h0000_0001);
        end
        // per output: follow when off, else step on an update
        for (int i = 0; i < 3; i++) begin
            if (!ramp_en[i]) begin
                // limiter off: output follows the target at once
                s_d.duty[i] = target[i];
                s_d.slow_cnt[i] = 2'h0;
            end else if (s_q.tick) begin
                s_d.slow_cnt[i] = 2'(s_q.slow_cnt[i] + 2'h1);
                // slow mode acts on every fourth update only
                if (step_due(slow_sel[i], s_q.slow_cnt[i])) begin
                    // target is compared fresh each update, so a dip that
                    // stays above the output keeps the ramp going up
                    s_d.duty[i] = ramp_next(s_q.duty[i], target[i],
                        step_amt[i]);
                end
            end
        end
    end

    // async reset parks every output at zero duty with the timer cleared
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q.tick_cnt <= 32'h0000_0000;
            s_q.tick <= 1'b0;
            s_q.slow_cnt <= {3{2'h0}};
            s_q.duty <= {3{`FRL_DUTY_RESET}};
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs, all from flip-flops
    // ****************************************************************
    assign o_reg_rdata = reg_rdata;
    assign o_duty1 = s_q.duty[0];
    assign o_duty2 = s_q.duty[1];
    assign o_duty3 = s_q.duty[2];
    assign o_update = s_q.tick;

endmodule : frl_ramp_limiter

`default_nettype wire

// File: frl_fan_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// fan rotor
// ****************
module frl_fan_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_duty,
    output logic [7:0] o_speed
);
    // rotor inertia: speed creeps one slot a cycle toward the drive
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst)
            o_speed <= 8'h00;
        else if (o_speed < i_duty)
            o_speed <= o_speed + 8'h01;
        else if (o_speed > i_duty)
            o_speed <= o_speed - 8'h01;
    end
endmodule : frl_fan_model
`default_nettype wire

// File: frl_ramp_limiter_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checks
// ****************
module frl_ramp_limiter_properties #(
    parameter int unsigned UPDATE_CYC = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_target_duty1,
    input wire logic [7:0] i_target_duty2,
    input wire logic [7:0] i_target_duty3,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [7:0] o_duty1,
    input wire logic [7:0] o_duty2,
    input wire logic [7:0] o_duty3,
    input wire logic o_update
);
    localparam int STEP[8] = '{1, 2, 3, 5, 8, 12, 24, 48};
    logic [7:0] a_q;
    logic [31:0] gap_q;
    logic seen_q;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // shadow of control a and update spacing; seen guards the first gap
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            a_q <= 8'h00;
            gap_q <= 32'h0;
            seen_q <= 1'b0;
        end else begin
            if (i_reg_wr && i_reg_addr == 8'h62)
                a_q <= i_reg_wdata;
            gap_q <= o_update ? 32'h0 : gap_q + 32'h1;
            seen_q <= seen_q | o_update;
        end
    end
    sequence s_pulse;
        o_update ##1 !o_update;
    endsequence
    a_upd_pulse: assert property (
        o_update |-> s_pulse) else $error("update pulse too long");
    a_upd_period: assert property (
        o_update && seen_q |-> gap_q == UPDATE_CYC - 1)
        else $error("update spacing wrong");
    a_hold_between: assert property (
        a_q[3] && !o_update |=> $stable(o_duty1))
        else $error("duty moved between updates");
    a_step_limit: assert property (
        o_update && a_q[3] |=> (o_duty1 >= $past(o_duty1) ?
        o_duty1 - $past(o_duty1) : $past(o_duty1) - o_duty1)
        <= STEP[$past(a_q[2:0])]) else $error("step too large");
    a_follow_off: assert property (
        !a_q[3] |=> o_duty1 == $past(i_target_duty1))
        else $error("disabled duty not following");
    a_rdata_hold: assert property (
        !i_reg_rd |=> $stable(o_reg_rdata)) else $error("read data moved");
    a_unmapped_rd: assert property (
        i_reg_rd && !(i_reg_addr inside {8'h5C, 8'h5D, 8'h5E, 8'h62,
        8'h63}) |=> o_reg_rdata == 8'h00) else $error("unmapped not zero");
    a_read_back: assert property (
        i_reg_rd && i_reg_addr == 8'h62 |=> o_reg_rdata == $past(a_q))
        else $error("control a read back wrong");
endmodule : frl_ramp_limiter_properties
bind frl_ramp_limiter frl_ramp_limiter_properties #(
    .UPDATE_CYC(UPDATE_CYC)
) u_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_target_duty1(i_target_duty1), .i_target_duty2(i_target_duty2),
    .i_target_duty3(i_target_duty3), .o_reg_rdata(o_reg_rdata),
    .o_duty1(o_duty1), .o_duty2(o_duty2), .o_duty3(o_duty3),
    .o_update(o_update)
);
`default_nettype wire

// File: test_frl_ramp_limiter.sv
`timescale 1ns/1ps
`default_nettype none
module test_frl_ramp_limiter
    import frl_pkg::*;
;
    // ****************
    // bench state
    // ****************
    localparam int STEP[8] = '{1, 2, 3, 5, 8, 12, 24, 48};
    localparam frl_byte_t ADR[6] = '{8'h5C, 8'h5D, 8'h5E, 8'h62, 8'h63, 8'h60};
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic upd;
    logic en;
    frl_byte_t addr = 8'h00, wd = 8'h00, rdat, ra = 8'h00, rb = 8'h00;
    frl_byte_t t[3] = '{default: 8'h00}, rc[3] = '{default: 8'h00};
    frl_byte_t d[3], spd[3];
    int err_count = 0, comparisons = 0, e[3] = '{0, 0, 0}, cnt[3];
    logic [31:0] lf = 32'hD754;
    frl_ramp_limiter #(.UPDATE_CYC(8)) u_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wdata(wd),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_target_duty1(t[0]),
        .i_target_duty2(t[1]), .i_target_duty3(t[2]), .o_reg_rdata(rdat),
        .o_duty1(d[0]), .o_duty2(d[1]), .o_duty3(d[2]), .o_update(upd));
    for (genvar g = 0; g < 3; g++) begin : g_fan
        frl_fan_model u_fan (.i_clk(i_clk), .i_rst(i_rst), .i_duty(d[g]),
            .o_speed(spd[g]));
    end
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    function automatic frl_byte_t rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf[7:0];
    endfunction : rnd
    task automatic check(input frl_byte_t got, input frl_byte_t exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    // register writes also update the bench copies
    task automatic wreg(input frl_byte_t a, input frl_byte_t v);
        @(posedge i_clk);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
        if (a == 8'h62) ra = v;
        if (a == 8'h63) rb = v;
        if (a inside {8'h5C, 8'h5D, 8'h5E}) rc[a - 8'h5C] = v;
    endtask : wreg
    task automatic rreg(input frl_byte_t a, input frl_byte_t v);
        @(posedge i_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1 check(rdat, v);
    endtask : rreg
    task automatic tgt(input frl_byte_t a, b, c);
        @(posedge i_clk);
        t <= '{a, b, c};
    endtask : tgt
    // wait for an update, then compare after the duty edge
    task automatic step_upd();
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            #1 n++;
        end while (upd !== 1'b1 && n < 40);
        if (upd !== 1'b1) begin
            err_count++;
            give_verdict();
        end
        @(posedge i_clk);
        #2 check(d[0], 8'(e[0]));
        check(d[1], 8'(e[1]));
        check(d[2], 8'(e[2]));
    endtask : step_upd
    // reference model runs every cycle, so updates that fall inside
    // register accesses or target changes are followed as well
    always @(posedge i_clk) begin : p_model
        int s;
        #1;
        for (int i = 0; i < 3; i++) begin
            en = (i == 0) ? ra[3] : (i == 1) ? rb[7] : rb[3];
            s = STEP[(i == 0) ? ra[2:0] : (i == 1) ? rb[6:4] : rb[2:0]];
            if (!en) begin
                e[i] = t[i];
                cnt[i] = 0;
            end else if (upd === 1'b1) begin
                if (!rc[i][3] || cnt[i] == 3)
                    e[i] = (t[i] > e[i]) ?
                        ((t[i] - e[i] < s) ? t[i] : e[i] + s) :
                        ((e[i] - t[i] < s) ? t[i] : e[i] - s);
                cnt[i] = (cnt[i] + 1) % 4;
            end
        end
    end
    // main sequence: reset values, every step code, slow ramps
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int k = 0; k < 6; k++)
            rreg(ADR[k], 8'h00);
        wreg(8'h60, 8'hA5);
        rreg(8'h60, 8'h00);
        tgt(rnd(), rnd(), rnd());
        step_upd();
        for (int c = 0; c < 8; c++) begin
            wreg(8'h62, 8'(8 + c));
            wreg(8'h63, 8'(8'h88 + c * 17));
            repeat (6) begin
                tgt(rnd(), rnd(), rnd());
                step_upd();
            end
        end
        wreg(8'h62, 8'h07);
        wreg(8'h63, 8'h77);
        tgt(8'h00, 8'h00, 8'h00);
        step_upd();
        for (int k = 0; k < 3; k++)
            wreg(8'(8'h5C + k), 8'h08);
        step_upd();
        wreg(8'h62, 8'h0F);
        wreg(8'h63, 8'hFF);
        tgt(8'hFF, 8'hFF, 8'hFF);
        repeat (28) step_upd();
        rreg(8'h5E, 8'h08);
        rreg(8'h63, 8'hFF);
        tgt(8'h00, 8'h00, 8'h00);
        repeat (10) step_upd();
        // limiters off: duty drops to zero and each fan spins down behind it
        wreg(8'h62, 8'h00);
        wreg(8'h63, 8'h00);
        repeat (260) @(posedge i_clk);
        #2;
        for (int k = 0; k < 3; k++)
            check(spd[k], 8'h00);
        give_verdict();
    end
endmodule : test_frl_ramp_limiter
`default_nettype wire
